// [verilog/scc_defines.vh]
// Constants shared by the serial channel core.
`ifndef SCC_DEFINES_VH
`define SCC_DEFINES_VH
// =====================================================================
// Register indices (byte address is four times the index)
`define SCC_IDX_DATA 3'h0
`define SCC_IDX_IER 3'h1
`define SCC_IDX_IIR 3'h2
`define SCC_IDX_LCR 3'h3
`define SCC_IDX_MCR 3'h4
`define SCC_IDX_LSR 3'h5
`define SCC_IDX_MSR 3'h6
`define SCC_IDX_SCR 3'h7
// =====================================================================
// Field positions
`define SCC_LCR_BANK 7
`define SCC_LCR_BRK 6
`define SCC_LCR_STICK 5
`define SCC_LCR_EPS 4
`define SCC_LCR_PEN 3
`define SCC_LCR_STB 2
`define SCC_MCR_LOOP 4
`define SCC_MCR_INTEN 3
`define SCC_FCR_EN 0
`define SCC_FCR_RXCLR 1
`define SCC_FCR_TXCLR 2
// =====================================================================
// Reset values
`define SCC_RST_BYTE 8'h00
`define SCC_RST_DIV 16'h0001
// =====================================================================
// Interrupt identification codes, bits 3:0
`define SCC_ID_NONE 4'h1
`define SCC_ID_LS 4'h6
`define SCC_ID_RDA 4'h4
`define SCC_ID_TO 4'hC
`define SCC_ID_TX_HOLDING_EMPTY 4'h2
`define SCC_ID_MS 4'h0
// =====================================================================
// Timing in ticks of the sixteen-times bit clock
`define SCC_TICK_LAST 5'h0F
`define SCC_TICK_HALF 5'h07
`define SCC_STOP1 6'h10
`define SCC_STOP15 6'h18
`define SCC_STOP2 6'h20
`define SCC_TIMEOUT_TICKS 10'h280
// =====================================================================
// Queues and trigger levels
`define SCC_DEPTH 5'h10
`define SCC_TRIG1 5'h01
`define SCC_TRIG4 5'h04
`define SCC_TRIG8 5'h08
`define SCC_TRIG14 5'h0E
`endif

// [verilog/scc_core.v]
// Serial channel core with APB register window, baud divisor and queues.
// Functional notes
// [RULE1] Baud generator divides input clock by sixteen-bit divisor, 1 to 65535.
// [RULE2] Frame: one start bit, 1/1.5/2 stops, even/odd/stick/no parity.
// [RULE3] Line control bit 7 banks offsets 0 and 1 onto divisor bytes.
// [RULE4] Characters five to eight bits, right-justified toward bit 0.
// [RULE5] Bit 0 is shifted out and captured first.
// [RULE6] Each direction has a shift register behind a holding register.
// [RULE7] Receive buffer is read-only, fed by hidden 8-bit deserialiser.
// [RULE8] Upper four interrupt enable bits always read zero.
// [RULE9] Enable bit 3 allows modem status interrupt on input change.
// [RULE10] Enable bit 2 allows line status interrupt on OE, PE, FE, break.
// [RULE11] Enable bit 1 allows transmit holding empty interrupt.
// [RULE12] Enable bit 0 allows data available, and timeout in queue mode.
// [RULE13] Priority: line status, data or timeout, transmit empty, modem.
// [RULE14] Identification value is frozen while host reads it.
// [RULE15] Ident bits 2:1: 11 line, 10 data, 01 transmit, 00 modem.
// [RULE16] Each source clears on its own read or write event.
// [RULE17] Ident bit 3 set with bit 2 for timeout, only in queue mode.
// [RULE18] Ident bits 7:6 one when queues enabled; bits 5:4 zero.
// [RULE19] Ident bit 0 is zero when any interrupt is pending.
// [RULE20] Baud generator output is sixteen times the bit rate.
// [RULE21] Line control bits 1:0 select five to eight data bits.
// [RULE22] Queue control bits 7:6 set trigger at 1, 4, 8 or 14.
// [RULE23] Interrupt pin driven only while modem control bit 3 set.
// [RULE24] Interrupt asserted while any enabled source is pending.
//
// Implementation choice: register access over APB.
`include "scc_defines.vh"
`default_nettype none
module scc_core (
  input wire core_clk,
  input wire rst_b,
  input wire [11:0] paddr,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire sin,
  output reg sout,
  input wire cts_n,
  input wire dsr_n,
  input wire ri_n,
  input wire carrier_detect_n,
  output reg rts_n,
  output reg dtr_n,
  output reg irq
);
  localparam [4:0] ST_IDLE = 5'h01;
  localparam [4:0] ST_START = 5'h02;
  localparam [4:0] ST_DATA = 5'h04;
  localparam [4:0] ST_PAR = 5'h08;
  localparam [4:0] ST_STOP = 5'h10;
  // =====================================================================
  // Input synchronisers
  reg [4:0] sync1;
  reg [4:0] sync2;
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      sync1 <= 5'h1F;
      sync2 <= 5'h1F;
    end else begin
      sync1 <= {sin, cts_n, dsr_n, ri_n, carrier_detect_n};
      sync2 <= sync1;
    end
  end
  // =====================================================================
  // Registers and bus decode
  reg [7:0] int_enable, line_control, modem_control, scratch_pad, queue_control;
  reg [15:0] divisor;
  reg [3:0] iir_hold;
  reg oe, pe, fe, bi, qerr, tx_holding_empty_int, to_flag;
  reg [3:0] msr_delta;
  reg [3:0] msr_prev;
  wire mapped = (paddr[11:5] == 7'h00) && (paddr[1:0] == 2'h0);
  wire [2:0] idx = paddr[4:2];
  wire done = psel & penable & pready;
  wire wr = done & pwrite & mapped;
  wire rd = done & ~pwrite & mapped;
  wire bank = line_control[`SCC_LCR_BANK];
  wire fifo_en = queue_control[`SCC_FCR_EN];
  wire loop = modem_control[`SCC_MCR_LOOP];
  wire wr_thr = wr & (idx == `SCC_IDX_DATA) & ~bank; // [RULE3]
  wire rd_rbr = rd & (idx == `SCC_IDX_DATA) & ~bank; // [RULE3]
  wire rd_iir = rd & (idx == `SCC_IDX_IIR);
  wire rd_lsr = rd & (idx == `SCC_IDX_LSR);
  wire rd_msr = rd & (idx == `SCC_IDX_MSR);
  wire wr_fcr = wr & (idx == `SCC_IDX_IIR) & pwdata[`SCC_FCR_EN];
  wire fcr_off = wr & (idx == `SCC_IDX_IIR) & ~pwdata[`SCC_FCR_EN] & fifo_en;
  wire [3:0] len = 4'h5 + {2'b00, line_control[1:0]}; // [RULE21]
  wire [7:0] dmask = 8'hFF >> (4'h8 - len);
  wire [4:0] limit = fifo_en ? `SCC_DEPTH : 5'h01;
  // =====================================================================
  // Baud tick: one pulse every divisor input clocks, sixteen per bit.
  reg [15:0] bcnt;
  reg tick;
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      bcnt <= 16'h0000;
      tick <= 1'b0;
    end else if (bcnt + 16'h0001 >= divisor) begin // [RULE1] [RULE20]
      bcnt <= 16'h0000;
      tick <= (divisor != 16'h0000);
    end else begin
      bcnt <= bcnt + 16'h0001;
      tick <= 1'b0;
    end
  end
  // =====================================================================
  // Queues; outside queue mode each holds a single entry.
  reg [10:0] rx_mem [0:15];
  reg [7:0] tx_mem [0:15];
  reg [3:0] rx_wp, rx_rp, tx_wp, tx_rp;
  reg [4:0] rx_cnt, tx_cnt;
  reg rx_push;
  reg [10:0] rx_word;
  wire tx_pop;
  wire rx_clr = fcr_off | (wr_fcr & (pwdata[`SCC_FCR_RXCLR] | ~fifo_en));
  wire tx_clr = fcr_off | (wr_fcr & (pwdata[`SCC_FCR_TXCLR] | ~fifo_en));
  wire rx_pop = rd_rbr & (rx_cnt != 5'h00);
  wire rx_ok = rx_push & (rx_cnt < limit);
  wire tx_ok = wr_thr & (tx_cnt < limit);
  always @(posedge core_clk) begin
    if (rx_ok)
      rx_mem[rx_wp] <= rx_word;
    if (tx_ok)
      tx_mem[tx_wp] <= pwdata[7:0];
  end
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_wp <= 4'h0;
      rx_rp <= 4'h0;
      rx_cnt <= 5'h00;
      tx_wp <= 4'h0;
      tx_rp <= 4'h0;
      tx_cnt <= 5'h00;
    end else begin
      if (rx_clr) begin
        rx_wp <= 4'h0;
        rx_rp <= 4'h0;
        rx_cnt <= 5'h00;
      end else begin
        rx_wp <= rx_wp + {3'h0, rx_ok};
        rx_rp <= rx_rp + {3'h0, rx_pop};
        rx_cnt <= rx_cnt + {4'h0, rx_ok} - {4'h0, rx_pop};
      end
      if (tx_clr) begin
        tx_wp <= 4'h0;
        tx_rp <= 4'h0;
        tx_cnt <= 5'h00;
      end else begin
        tx_wp <= tx_wp + {3'h0, tx_ok};
        tx_rp <= tx_rp + {3'h0, tx_pop};
        tx_cnt <= tx_cnt + {4'h0, tx_ok} - {4'h0, tx_pop};
      end
    end
  end
  // =====================================================================
  // Transmitter: shift register behind the holding queue.
  reg [4:0] tx_st;
  reg [5:0] tx_tc;
  reg [2:0] tx_bc;
  reg [7:0] tx_sh;
  reg tx_line, tx_par;
  wire [5:0] stop_len = ~line_control[`SCC_LCR_STB] ? `SCC_STOP1 :
                        (line_control[1:0] == 2'b00) ? `SCC_STOP15 : `SCC_STOP2; // [RULE2]
  wire tx_bit_end = tick & (tx_tc[4:0] == `SCC_TICK_LAST);
  assign tx_pop = (tx_st == ST_IDLE) & (tx_cnt != 5'h00) & ~tx_clr; // [RULE6]
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_st <= ST_IDLE;
      tx_tc <= 6'h00;
      tx_bc <= 3'h0;
      tx_sh <= 8'h00;
      tx_line <= 1'b1;
      tx_par <= 1'b0;
    end else begin
      if (tick)
        tx_tc <= tx_tc + 6'h01;
      case (tx_st)
        ST_IDLE: begin
          tx_line <= 1'b1;
          if (tx_pop) begin
            tx_sh <= tx_mem[tx_rp] & dmask; // [RULE4]
            tx_par <= ^(tx_mem[tx_rp] & dmask);
            tx_tc <= 6'h00;
            tx_line <= 1'b0;
            tx_st <= ST_START;
          end
        end
        ST_START: begin
          if (tx_bit_end) begin
            tx_tc <= 6'h00;
            tx_bc <= 3'h0;
            tx_line <= tx_sh[0]; // [RULE5]
            tx_st <= ST_DATA;
          end
        end
        ST_DATA: begin
          if (tx_bit_end) begin
            tx_tc <= 6'h00;
            tx_sh <= {1'b0, tx_sh[7:1]};
            tx_bc <= tx_bc + 3'h1;
            if ({1'b0, tx_bc} == len - 4'h1) begin
              if (line_control[`SCC_LCR_PEN]) begin
                tx_line <= line_control[`SCC_LCR_STICK] ? ~line_control[`SCC_LCR_EPS] :
                           (tx_par ^ ~line_control[`SCC_LCR_EPS]); // [RULE2]
                tx_st <= ST_PAR;
              end else begin
                tx_line <= 1'b1;
                tx_st <= ST_STOP;
              end
            end else begin
              tx_line <= tx_sh[1];
            end
          end
        end
        ST_PAR: begin
          if (tx_bit_end) begin
            tx_tc <= 6'h00;
            tx_line <= 1'b1;
            tx_st <= ST_STOP;
          end
        end
        ST_STOP: begin
          if (tick && tx_tc == stop_len - 6'h01)
            tx_st <= ST_IDLE;
        end
        default: tx_st <= ST_IDLE;
      endcase
    end
  end
  // =====================================================================
  // Receiver: hidden deserialiser; only the first stop bit is checked.
  reg [4:0] rx_st;
  reg [4:0] rx_tc;
  reg [2:0] rx_bc;
  reg [7:0] rx_sh;
  reg rx_perr;
  wire rx_in = loop ? tx_line : sync2[4];
  wire rx_mid = tick & (rx_tc == `SCC_TICK_LAST);
  wire [7:0] rx_data = rx_sh >> (4'h8 - len); // [RULE4]
  // Parity is taken over the right-justified word so short characters check correctly.
  wire rx_exp = line_control[`SCC_LCR_STICK] ? ~line_control[`SCC_LCR_EPS] :
                (^rx_data) ^ ~line_control[`SCC_LCR_EPS];
  wire rx_zero = (rx_data == 8'h00) & ~rx_in;
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_st <= ST_IDLE;
      rx_tc <= 5'h00;
      rx_bc <= 3'h0;
      rx_sh <= 8'h00;
      rx_perr <= 1'b0;
      rx_push <= 1'b0;
      rx_word <= 11'h000;
    end else begin
      rx_push <= 1'b0;
      if (tick)
        rx_tc <= rx_tc + 5'h01;
      case (rx_st)
        ST_IDLE: begin
          rx_tc <= 5'h00;
          rx_perr <= 1'b0;
          if (!rx_in)
            rx_st <= ST_START;
        end
        ST_START: begin
          if (tick && rx_tc == `SCC_TICK_HALF) begin
            rx_tc <= 5'h00;
            rx_bc <= 3'h0;
            rx_st <= rx_in ? ST_IDLE : ST_DATA;
          end
        end
        ST_DATA: begin
          if (rx_mid) begin
            rx_tc <= 5'h00;
            rx_sh <= {rx_in, rx_sh[7:1]}; // [RULE5] [RULE7]
            rx_bc <= rx_bc + 3'h1;
            if ({1'b0, rx_bc} == len - 4'h1)
              rx_st <= line_control[`SCC_LCR_PEN] ? ST_PAR : ST_STOP;
          end
        end
        ST_PAR: begin
          if (rx_mid) begin
            rx_tc <= 5'h00;
            rx_sh <= rx_data;
            rx_perr <= (rx_in != rx_exp); // [RULE2]
            rx_st <= ST_STOP;
          end
        end
        ST_STOP: begin
          if (rx_mid) begin
            rx_push <= 1'b1;
            rx_word <= {rx_zero, ~rx_in, rx_perr,
                        line_control[`SCC_LCR_PEN] ? rx_sh : rx_data};
            rx_st <= ST_IDLE;
          end
        end
        default: rx_st <= ST_IDLE;
      endcase
    end
  end
  // =====================================================================
  // Status flags and interrupt sources; a set wins over a read clear.
  wire [3:0] mstate = loop ? {modem_control[`SCC_MCR_INTEN], modem_control[2], modem_control[0], modem_control[1]} :
                      ~{sync2[0], sync2[1], sync2[2], sync2[3]};
  wire [3:0] mchg = {mstate[3] ^ msr_prev[3], ~mstate[2] & msr_prev[2],
                     mstate[1:0] ^ msr_prev[1:0]};
  wire tx_empty = (tx_cnt == 5'h00);
  reg tx_empty_d;
  reg [9:0] to_cnt;
  reg [4:0] trig;
  always @* begin
    case (queue_control[7:6]) // [RULE22]
      2'b00: trig = `SCC_TRIG1;
      2'b01: trig = `SCC_TRIG4;
      2'b10: trig = `SCC_TRIG8;
      default: trig = `SCC_TRIG14;
    endcase
  end
  wire src_ls = int_enable[2] & (oe | pe | fe | bi); // [RULE10]
  wire src_rda = int_enable[0] & (fifo_en ? (rx_cnt >= trig) : (rx_cnt != 5'h00)); // [RULE12]
  wire src_to = int_enable[0] & fifo_en & to_flag; // [RULE12]
  wire src_tx_holding_empty = int_enable[1] & tx_holding_empty_int; // [RULE11]
  wire src_ms = int_enable[3] & (msr_delta != 4'h0); // [RULE9]
  reg [3:0] iir_live;
  always @* begin
    if (src_ls) // [RULE13] [RULE15]
      iir_live = `SCC_ID_LS;
    else if (src_to)
      iir_live = `SCC_ID_TO; // [RULE17]
    else if (src_rda)
      iir_live = `SCC_ID_RDA;
    else if (src_tx_holding_empty)
      iir_live = `SCC_ID_TX_HOLDING_EMPTY;
    else if (src_ms)
      iir_live = `SCC_ID_MS;
    else
      iir_live = `SCC_ID_NONE; // [RULE19]
  end
  wire iir_busy = psel & ~pwrite & mapped & (idx == `SCC_IDX_IIR);
  wire head_err = fifo_en & rx_ok & (rx_word[10:8] != 3'h0);
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      iir_hold <= `SCC_ID_NONE;
      oe <= 1'b0;
      pe <= 1'b0;
      fe <= 1'b0;
      bi <= 1'b0;
      qerr <= 1'b0;
      tx_holding_empty_int <= 1'b0;
      tx_empty_d <= 1'b1;
      to_flag <= 1'b0;
      to_cnt <= 10'h000;
      msr_delta <= 4'h0;
      msr_prev <= 4'h0;
    end else begin
      if (!iir_busy)
        iir_hold <= iir_live; // [RULE14]
      oe <= (rx_push & ~rx_ok) | (oe & ~rd_lsr); // [RULE16]
      pe <= (rx_ok & rx_word[8]) | (pe & ~rd_lsr);
      fe <= (rx_ok & rx_word[9]) | (fe & ~rd_lsr);
      bi <= (rx_ok & rx_word[10]) | (bi & ~rd_lsr);
      qerr <= head_err | (qerr & ~rd_lsr);
      tx_empty_d <= tx_empty;
      tx_holding_empty_int <= (tx_empty & ~tx_empty_d) |
                  (wr & ~bank & (idx == `SCC_IDX_IER) & pwdata[1] & ~int_enable[1] & tx_empty) |
                  (tx_holding_empty_int & ~wr_thr & ~(rd_iir & iir_hold == `SCC_ID_TX_HOLDING_EMPTY)); // [RULE16]
      if (rx_ok || rx_pop || rx_cnt == 5'h00 || !fifo_en)
        to_cnt <= 10'h000;
      else if (tick && to_cnt != `SCC_TIMEOUT_TICKS)
        to_cnt <= to_cnt + 10'h001;
      to_flag <= (fifo_en & rx_cnt != 5'h00 & tick & to_cnt == `SCC_TIMEOUT_TICKS - 10'h001) |
                 (to_flag & ~rx_pop & fifo_en); // [RULE16]
      msr_prev <= mstate;
      msr_delta <= mchg | (msr_delta & {4{~rd_msr}}); // [RULE9] [RULE16]
    end
  end
  // =====================================================================
  // Bus slave: one wait state, registered read data.
  reg [7:0] rdata;
  always @* begin
    case (idx)
      `SCC_IDX_DATA: rdata = bank ? divisor[7:0] : rx_mem[rx_rp][7:0]; // [RULE3] [RULE7]
      `SCC_IDX_IER: rdata = bank ? divisor[15:8] : {4'h0, int_enable[3:0]}; // [RULE8]
      `SCC_IDX_IIR: rdata = {{2{fifo_en}}, 2'b00, iir_hold}; // [RULE18]
      `SCC_IDX_LCR: rdata = line_control;
      `SCC_IDX_MCR: rdata = {3'b000, modem_control[4:0]};
      `SCC_IDX_LSR: rdata = {qerr, tx_empty & (tx_st == ST_IDLE), tx_empty,
                             bi, fe, pe, oe, rx_cnt != 5'h00};
      `SCC_IDX_MSR: rdata = {mstate, msr_delta};
      default: rdata = scratch_pad;
    endcase
  end
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
      int_enable <= `SCC_RST_BYTE;
      line_control <= `SCC_RST_BYTE;
      modem_control <= `SCC_RST_BYTE;
      scratch_pad <= `SCC_RST_BYTE;
      queue_control <= `SCC_RST_BYTE;
      divisor <= `SCC_RST_DIV;
    end else begin
      pready <= psel & penable & ~pready;
      if (psel && penable && !pready) begin
        pslverr <= ~mapped;
        prdata <= (mapped & ~pwrite) ? {24'h000000, rdata} : 32'h00000000;
      end
      if (wr) begin
        case (idx)
          `SCC_IDX_DATA: if (bank) divisor[7:0] <= pwdata[7:0]; // [RULE3]
          `SCC_IDX_IER: begin
            if (bank)
              divisor[15:8] <= pwdata[7:0];
            else
              int_enable <= {4'h0, pwdata[3:0]}; // [RULE8]
          end
          `SCC_IDX_IIR: queue_control <= pwdata[`SCC_FCR_EN] ? {pwdata[7:6], 5'h00, 1'b1} : `SCC_RST_BYTE;
          `SCC_IDX_LCR: line_control <= pwdata[7:0];
          `SCC_IDX_MCR: modem_control <= {3'b000, pwdata[4:0]};
          `SCC_IDX_SCR: scratch_pad <= pwdata[7:0];
          default: scratch_pad <= scratch_pad;
        endcase
      end
    end
  end
  // =====================================================================
  // Pins; loopback parks the line and modem outputs in the idle state.
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      sout <= 1'b1;
      rts_n <= 1'b1;
      dtr_n <= 1'b1;
      irq <= 1'b0;
    end else begin
      sout <= loop | (tx_line & ~line_control[`SCC_LCR_BRK]);
      rts_n <= loop | ~modem_control[1];
      dtr_n <= loop | ~modem_control[0];
      irq <= modem_control[`SCC_MCR_INTEN] & (iir_live != `SCC_ID_NONE); // [RULE23] [RULE24]
    end
  end
endmodule
`default_nettype wire

// [tb/scc_core_assertions.sv]
// Port-level checker for the serial channel core.
`include "scc_defines.vh"
`default_nettype none
module scc_core_assertions (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 100ps;
  // =====================================================================
  // Shadow of the few control bits the properties depend on
  logic bank;
  logic fifo;
  logic gate;
  logic [7:0] div_lo;
  logic wr;
  logic rd;
  logic id_sel;
  assign wr = psel && penable && pready && pwrite;
  assign rd = psel && penable && pready && !pwrite;
  assign id_sel = paddr == 12'h008;
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      bank <= 1'b0;
      fifo <= 1'b0;
      gate <= 1'b0;
      div_lo <= 8'h01;
    end else if (wr) begin
      if (paddr == 12'h00C) begin
        bank <= pwdata[7];
      end
      if (id_sel) begin
        fifo <= pwdata[0];
      end
      if (paddr == 12'h010) begin
        gate <= pwdata[3];
      end
      if (paddr == 12'h000 && bank) begin
        div_lo <= pwdata[7:0];
      end
    end
  end
  // =====================================================================
  // Properties
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  AST_APB_TWO_CYCLE:
    assert property (psel && !penable |=> !pready ##1 pready)
    else $error("pready not two cycles after setup");
  AST_IER_UPPER:
    assert property (rd && paddr == 12'h004 && !bank |-> prdata[7:4] == 4'h0)
    else $error("interrupt enable upper bits not zero");
  AST_DIV_LOW:
    assert property (rd && paddr == 12'h000 && bank |-> prdata[7:0] == div_lo)
    else $error("divisor low byte not reachable at offset zero");
  AST_IIR_CODE:
    assert property (rd && id_sel |-> prdata[3:0] inside {`SCC_ID_NONE, `SCC_ID_LS,
      `SCC_ID_RDA, `SCC_ID_TO, `SCC_ID_TX_HOLDING_EMPTY, `SCC_ID_MS})
    else $error("illegal identification code");
  AST_IIR_BIT3:
    assert property (rd && id_sel && !fifo |-> !prdata[3])
    else $error("timeout flag outside queue mode");
  AST_IIR_TOP:
    assert property (rd && id_sel |-> prdata[7:4] == (fifo ? 4'hC : 4'h0))
    else $error("identification upper bits wrong");
  AST_IRQ_GATE:
    assert property (!gate |=> !irq)
    else $error("irq driven while output gate is off");
  AST_IRQ_PEND:
    assert property (rd && id_sel && !prdata[0] && gate |-> ##[0:1] irq)
    else $error("pending source without irq");
  COV_TX_HOLDING_EMPTY: cover property (rd && id_sel && prdata[3:0] == `SCC_ID_TX_HOLDING_EMPTY);
  COV_LS: cover property (rd && id_sel && prdata[3:0] == `SCC_ID_LS);
  COV_IRQ: cover property ($rose(irq));
endmodule
bind scc_core scc_core_assertions u_chk (
  .core_clk(core_clk), .rst_b(rst_b), .paddr(paddr), .psel(psel),
  .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .irq(irq)
);
`default_nettype wire

// [tb/scc_far_end.sv]
// Far-end serial terminal model: sends on sin, decodes sout.
`default_nettype none
module scc_far_end #(
  parameter int BIT_NS = 128
) (
  input wire logic sout,
  input wire logic send,
  input wire logic [7:0] send_byte,
  input wire logic bad_stop,
  output logic sin,
  output logic [7:0] got_byte,
  output logic [7:0] got_count
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    sin = 1'b1;
    got_byte = 8'h00;
    got_count = 8'h00;
  end
  // =====================================================================
  // Sender; the line rests at mark between frames.
  always @(posedge send) begin
    #1;
    sin = 1'b0;
    #(BIT_NS);
    for (int i = 0; i < 8; i++) begin
      sin = send_byte[i];
      #(BIT_NS);
    end
    sin = !bad_stop;
    // A broken stop ends early so the receiver cannot take it for a start.
    #(BIT_NS * 3 / 4);
    sin = 1'b1;
    #(BIT_NS);
  end
  // =====================================================================
  // Receiver of eight data bits
  always begin
    @(negedge sout);
    #(BIT_NS / 2);
    for (int i = 0; i < 8; i++) begin
      #(BIT_NS);
      got_byte[i] = sout;
    end
    #(BIT_NS);
    got_count = got_count + 8'h01;
  end
endmodule
`default_nettype wire

// [tb/scc_core_test.sv]
// Self-checking bench for the serial channel core.
`include "scc_defines.vh"
`default_nettype none
module scc_core_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic sin;
  logic sout;
  logic cts_n = 1'b1;
  logic rts_n;
  logic dtr_n;
  logic irq;
  logic send = 1'b0;
  logic [7:0] send_byte = 8'h00;
  logic bad_stop = 1'b0;
  logic [7:0] got_byte;
  logic [7:0] got_count;
  logic [31:0] q;
  logic e;
  int bad_count = 0;
  int checks = 0;
  scc_core DUT (
    .core_clk(core_clk), .rst_b(rst_b), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sin(sin), .sout(sout), .cts_n(cts_n),
    .dsr_n(1'b1), .ri_n(1'b1), .carrier_detect_n(1'b1), .rts_n(rts_n),
    .dtr_n(dtr_n), .irq(irq)
  );
  scc_far_end #(.BIT_NS(128)) far (
    .sout(sout), .send(send), .send_byte(send_byte), .bad_stop(bad_stop),
    .sin(sin), .got_byte(got_byte), .got_count(got_count)
  );
  initial begin
    forever #2 core_clk = ~core_clk;
  end
  // =====================================================================
  // Shared tasks
  task automatic stop_test();
    $display("checks=%0d bad_count=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  function automatic logic [11:0] ra(input logic [2:0] i);
    return {7'h00, i, 2'h0};
  endfunction
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n == 20) begin
      bad_count++;
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic wr(input logic [2:0] i, input logic [7:0] d);
    apb(1'b1, ra(i), d);
  endtask
  task automatic rd_chk(input logic [2:0] i, input logic [7:0] x);
    apb(1'b0, ra(i), 8'h00);
    chk(q, {24'h000000, x});
  endtask
  task automatic wait_irq(input logic v);
    int n;
    n = 0;
    while (irq !== v && n < 1000) begin
      @(posedge core_clk);
      n++;
    end
    chk({31'h0, irq}, {31'h0, v});
  endtask
  task automatic wait_rx(input logic [7:0] c, input logic [7:0] x);
    int n;
    n = 0;
    while (got_count !== c && n < 1000) begin
      @(posedge core_clk);
      n++;
    end
    chk({24'h000000, got_byte}, {24'h000000, x});
  endtask
  task automatic send_char(input logic [7:0] b, input logic bad);
    repeat (64) @(posedge core_clk);
    send_byte <= b;
    bad_stop <= bad;
    send <= 1'b1;
    @(posedge core_clk);
    send <= 1'b0;
  endtask
  // =====================================================================
  // Scenarios
  task automatic t_regs();
    chk({28'h0, sout, rts_n, dtr_n, irq}, 32'hE);
    rd_chk(`SCC_IDX_LCR, 8'h00);
    rd_chk(`SCC_IDX_IIR, 8'h01);
    wr(`SCC_IDX_IER, 8'hFF);
    rd_chk(`SCC_IDX_IER, 8'h0F);
    wr(`SCC_IDX_SCR, 8'h5A);
    rd_chk(`SCC_IDX_SCR, 8'h5A);
    apb(1'b0, 12'h020, 8'h00);
    chk({q[30:0], e}, 32'h1);
    apb(1'b1, 12'h006, 8'h00);
    chk({31'h0, e}, 32'h1);
  endtask
  task automatic t_bank();
    wr(`SCC_IDX_IER, 8'h05);
    wr(`SCC_IDX_LCR, 8'h83);
    wr(`SCC_IDX_DATA, 8'h02);
    wr(`SCC_IDX_IER, 8'h00);
    rd_chk(`SCC_IDX_DATA, 8'h02);
    rd_chk(`SCC_IDX_IER, 8'h00);
    wr(`SCC_IDX_LCR, 8'h03);
    rd_chk(`SCC_IDX_IER, 8'h05);
  endtask
  task automatic t_tx();
    wr(`SCC_IDX_MCR, 8'h0B);
    @(posedge core_clk);
    chk({30'h0, rts_n, dtr_n}, 32'h0);
    wr(`SCC_IDX_DATA, 8'hA5);
    wr(`SCC_IDX_DATA, 8'h5A);
    wait_rx(8'h01, 8'hA5);
    wait_rx(8'h02, 8'h5A);
    wr(`SCC_IDX_LCR, 8'h00);
    wr(`SCC_IDX_DATA, 8'h1F);
    wait_rx(8'h03, 8'hFF);
    wr(`SCC_IDX_LCR, 8'h03);
    wr(`SCC_IDX_IER, 8'h02);
    wait_irq(1'b1);
    rd_chk(`SCC_IDX_IIR, {4'h0, `SCC_ID_TX_HOLDING_EMPTY});
    rd_chk(`SCC_IDX_IIR, 8'h01);
    wait_irq(1'b0);
  endtask
  task automatic t_rx();
    wr(`SCC_IDX_IER, 8'h01);
    send_char(8'h3C, 1'b0);
    wait_irq(1'b1);
    rd_chk(`SCC_IDX_IIR, {4'h0, `SCC_ID_RDA});
    rd_chk(`SCC_IDX_DATA, 8'h3C);
    rd_chk(`SCC_IDX_IIR, 8'h01);
  endtask
  task automatic t_line();
    wr(`SCC_IDX_IER, 8'h05);
    send_char(8'h55, 1'b1);
    wait_irq(1'b1);
    rd_chk(`SCC_IDX_IIR, {4'h0, `SCC_ID_LS});
    rd_chk(`SCC_IDX_LSR, 8'h69);
    rd_chk(`SCC_IDX_IIR, {4'h0, `SCC_ID_RDA});
    rd_chk(`SCC_IDX_DATA, 8'h55);
    rd_chk(`SCC_IDX_IIR, 8'h01);
  endtask
  task automatic t_modem();
    wr(`SCC_IDX_IER, 8'h08);
    cts_n <= 1'b0;
    wait_irq(1'b1);
    rd_chk(`SCC_IDX_IIR, {4'h0, `SCC_ID_MS});
    wr(`SCC_IDX_MCR, 8'h03);
    wait_irq(1'b0);
    apb(1'b0, ra(`SCC_IDX_MSR), 8'h00);
    chk(q & 32'h11, 32'h11);
    rd_chk(`SCC_IDX_IIR, 8'h01);
    cts_n <= 1'b1;
  endtask
  task automatic t_queue();
    wr(`SCC_IDX_IER, 8'h00);
    wr(`SCC_IDX_IIR, 8'h01);
    rd_chk(`SCC_IDX_IIR, 8'hC1);
    wr(`SCC_IDX_IIR, 8'h00);
    rd_chk(`SCC_IDX_IIR, 8'h01);
  endtask
  task automatic t_loop();
    wr(`SCC_IDX_LCR, 8'h1B);
    wr(`SCC_IDX_MCR, 8'h1B);
    wr(`SCC_IDX_DATA, 8'h96);
    repeat (400) @(posedge core_clk);
    rd_chk(`SCC_IDX_LSR, 8'h61);
    rd_chk(`SCC_IDX_DATA, 8'h96);
  endtask
  // =====================================================================
  // Main sequence and watchdog
  initial begin
    repeat (6) @(posedge core_clk);
    rst_b <= 1'b1;
    @(posedge core_clk);
    t_regs();
    t_bank();
    t_tx();
    t_rx();
    t_line();
    t_modem();
    t_queue();
    t_loop();
    stop_test();
  end
  initial begin
    #100000;
    bad_count++;
    stop_test();
  end
endmodule
`default_nettype wire
